// *** core/pmcc_pkg.sv ***
package pmcc_pkg;
   // command codes of the command port (standard management-bus codes)
   localparam logic [7:0] CMD_OPERATION = 8'h01; // operation_control
   localparam logic [7:0] CMD_ONOFF_CFG = 8'h02; // on_off_configuration
   localparam logic [7:0] CMD_STORE_ALL = 8'h11; // store all defaults (send byte)
   localparam logic [7:0] CMD_VOUT_MODE = 8'h20; // output voltage mode
   localparam logic [7:0] CMD_VOUT_SET = 8'h21; // output_voltage_setpoint
   localparam logic [7:0] CMD_MARGIN_HI = 8'h25; // margin high set point
   localparam logic [7:0] CMD_MARGIN_LO = 8'h26; // margin low set point
   localparam logic [7:0] CMD_VIN_ON = 8'h35; // input_turn_on_threshold
   localparam logic [7:0] CMD_VIN_OFF = 8'h36; // input_turn_off_threshold
   localparam logic [7:0] CMD_TURN_ON_DELAY_TIME = 8'h60; // turn_on_delay_time
   localparam logic [7:0] CMD_SOFT_START_RISE_TIME = 8'h61; // soft_start_rise_time
   localparam logic [7:0] CMD_VIN_READ = 8'h88; // input_voltage_readback
   localparam logic [7:0] CMD_VOUT_READ = 8'h8B; // output_voltage_readback
   localparam logic [7:0] CMD_VIN_OFS = 8'hD0; // input_voltage_cal_offset
   localparam logic [7:0] CMD_VIN_GAIN = 8'hD1; // input_voltage_cal_gain
   localparam logic [7:0] CMD_VOUT_OFS = 8'hD2; // output_voltage_cal_offset
   // field positions
   localparam int OP_ON_BIT = 7; // enable bit of operation byte
   localparam int CFG_CMD_BIT = 3; // command-response bit
   localparam int LIN_EXP_LSB = 11; // exponent field [15:11]
   // fixed exponents, 5-bit two's complement
   localparam logic [4:0] EXP_M3 = 5'h1D; // -3
   localparam logic [4:0] EXP_M1 = 5'h1F; // -1
   localparam logic [7:0] VOUT_MODE_VAL = 8'h14; // linear mode, exponent -12
   // reset values
   localparam logic [7:0] OP_RST = 8'h00; // output off, margin off
   localparam logic [4:0] CFG_RST = 5'h1F; // all five bits set
   localparam logic [10:0] VIN_ON_RST = 11'h110; // 34.0 V
   localparam logic [10:0] VIN_OFF_RST = 11'h100; // 32.0 V
   localparam logic [10:0] TON_DLY_RST = 11'h014; // 10 ms
   localparam logic [10:0] SOFT_START_RISE_TIME_RST = 11'h01E; // 15 ms
   localparam logic [15:0] VOUT_RST = 16'hC000; // 12.0 V
   localparam logic [15:0] MHI_RST = 16'hC666; // 12.4 V
   localparam logic [15:0] MLO_RST = 16'hB99A; // 11.6 V
   // ranges in mantissa units
   localparam logic [10:0] VIN_MIN = 11'h100; // 32.000 V
   localparam logic [10:0] VIN_MAX = 11'h170; // 46.000 V
   localparam logic [10:0] DLY_MIN = 11'h014; // 10 ms
   localparam logic [10:0] RISE_MIN = 11'h01E; // 15 ms
   localparam logic [10:0] TIME_MAX = 11'h3E8; // 500 ms
   localparam logic [15:0] VOUT_MIN = 16'h819A; // 8.10 V
   localparam logic [15:0] VOUT_MAX = 16'hD333; // 13.20 V
   // timing: one mantissa step is half a millisecond
   localparam int CLK_MHZ = 100;
   localparam int STEP_US = 500;
   localparam int STEP_CYC = STEP_US * CLK_MHZ;
   localparam int GAIN_SHIFT = 13; // divide by 8192
   // sequencer states
   typedef enum logic [1:0] {
      PMCC_OFF = 2'b00,
      PMCC_DELAY = 2'b01,
      PMCC_RISE = 2'b10,
      PMCC_ON = 2'b11
   } pmcc_state_t;
endpackage

// *** core/pmcc_cal.sv ***
`timescale 1ns/1ns
`default_nettype none
// corrects raw conversions with offset, the input one also with gain, registered outputs
module pmcc_cal
   import pmcc_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic CE,
   input wire logic [15:0] vout_raw,
   input wire logic [15:0] vout_ofs,
   input wire logic [10:0] vin_raw,
   input wire logic [10:0] vin_ofs,
   input wire logic [15:0] vin_gain,
   output logic [15:0] vout_q,
   output logic [10:0] vin_q
);
   logic [26:0] vin_prod; // raw times gain
   logic signed [17:0] vin_sum; // scaled plus offset
   logic signed [17:0] vout_sum; // raw plus offset
   always_comb begin
      vin_prod = 27'(vin_raw) * 27'(vin_gain);
      vin_sum = $signed({4'h0, vin_prod[26:GAIN_SHIFT]}) + 18'(signed'(vin_ofs));
      vout_sum = $signed({2'b00, vout_raw}) + 18'(signed'(vout_ofs));
   end
   // clamp into the representable positive ranges
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         vout_q <= 16'h0000;
         vin_q <= 11'h000;
      end else if (CE) begin
         if (vout_sum < 0) vout_q <= 16'h0000;
         else if (vout_sum > 18'sh0FFFF) vout_q <= 16'hFFFF;
         else vout_q <= vout_sum[15:0];
         if (vin_sum < 0) vin_q <= 11'h000;
         else if (vin_sum > 18'sh003FF) vin_q <= 11'h3FF;
         else vin_q <= vin_sum[10:0];
      end
   end
endmodule
`default_nettype wire

// *** core/pmcc_top.sv ***
// Notes on behaviour
// - operation bit 7 enables the output
// - five config bits, bit 3 writable, all one
// - command bit clear ignores operation enable
// - output needs enable pin asserted
// - stay off until pin and command agree
// - thresholds 32 to 46 V, 0.125 V steps
// - threshold words exponent -3, positive mantissa
// - turn-on delay 10-500 ms, then ramp
// - rise time 15-500 ms sets ramp length
// - time words exponent -1, positive mantissa
// - set point unsigned, exponent -12, mode reports
// - set point limited 8.10 to 13.20 V
// - separate margin high and low set points
// - operation bits 5:2 select margin
// - output readback unsigned, exponent -12
// - output readback adds readable factory offset
// - input readback exponent -3, positive mantissa
// - input offset exponent -3, signed mantissa
// - input readback scaled by gain over 8192
// - settings persist only on store command
`timescale 1ns/1ns
`default_nettype none
module pmcc_top
   import pmcc_pkg::*;
#(
   parameter int STEP_CYCLES = STEP_CYC // cycles per half millisecond
)(
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic CE, // freezes all state when low
   input wire logic WR_STB, // one-cycle write strobe
   input wire logic RD_STB, // one-cycle read strobe
   input wire logic [7:0] CMD, // command code
   input wire logic [15:0] WDATA, // write word, bytes in low for byte commands
   output logic [15:0] RDATA, // read word
   output logic RVALID, // read answer pulse
   output logic CMD_ERR, // unsupported command pulse
   output logic DATA_ERR, // invalid data pulse
   input wire logic EN_PIN, // analog on/off pin, high asserted
   input wire logic [15:0] VOUT_ADC, // raw output conversion
   input wire logic [10:0] VIN_ADC, // raw input conversion
   input wire logic [15:0] NV_VOUT_OFS, // factory output offset
   input wire logic [10:0] NV_VIN_OFS, // factory input offset
   input wire logic [15:0] NV_VIN_GAIN, // factory input gain
   output logic NV_STORE, // pulse: commit working settings
   output logic OUT_EN, // power stage enable
   output logic RAMPING, // output ramp in progress
   output logic [15:0] VOUT_TARGET, // present set point in use
   output logic [15:0] RAMP_CNT // half-millisecond steps into phase
);
   // elaboration check: the tick counter needs at least one cycle per step
   if (STEP_CYCLES < 1) begin : g_step_check
      $error("STEP_CYCLES must be at least one");
   end

   // working settings
   logic [7:0] op_q; // operation_control
   logic cfg_cmd_q; // command-response bit
   logic [10:0] vin_on_q; // turn-on threshold mantissa
   logic [10:0] vin_off_q; // turn-off threshold mantissa
   logic [10:0] dly_q; // turn-on delay mantissa
   logic [10:0] rise_q; // rise time mantissa
   logic [15:0] vout_q; // set point
   logic [15:0] mhi_q; // margin high
   logic [15:0] mlo_q; // margin low
   logic [15:0] rb_vout; // corrected output reading
   logic [10:0] rb_vin; // corrected input reading
   logic run_req; // output wanted by pin and command
   logic [10:0] w_mant; // low eleven bits of a write
   logic lin_ok_m3; // exponent -3, top mantissa bit clear
   logic lin_ok_m1; // exponent -1, top mantissa bit clear
   logic wr_ok; // write accepted
   logic wr_bad; // write refused
   logic known; // command accepts writes
   pmcc_state_t st_q; // sequencer state
   logic [31:0] tick_q; // cycles into current half millisecond
   logic step; // half millisecond elapsed

   assign w_mant = WDATA[10:0];
   assign lin_ok_m3 = (WDATA[15:LIN_EXP_LSB] == EXP_M3) && !WDATA[10];
   assign lin_ok_m1 = (WDATA[15:LIN_EXP_LSB] == EXP_M1) && !WDATA[10];

   // range check for each writable command
   // a refused write only pulses DATA_ERR; the stored word is left untouched
   always_comb begin
      wr_ok = 1'b0;
      known = 1'b1;
      if (CMD == CMD_OPERATION) begin
         wr_ok = 1'b1;
      end else if (CMD == CMD_ONOFF_CFG) begin
         wr_ok = 1'b1;
      end else if (CMD == CMD_STORE_ALL) begin
         wr_ok = 1'b1;
      end else if (CMD == CMD_VIN_ON || CMD == CMD_VIN_OFF) begin
         wr_ok = lin_ok_m3 && w_mant >= VIN_MIN && w_mant <= VIN_MAX;
      end else if (CMD == CMD_TURN_ON_DELAY_TIME) begin
         wr_ok = lin_ok_m1 && w_mant >= DLY_MIN && w_mant <= TIME_MAX;
      end else if (CMD == CMD_SOFT_START_RISE_TIME) begin
         wr_ok = lin_ok_m1 && w_mant >= RISE_MIN && w_mant <= TIME_MAX;
      end else if (CMD == CMD_VOUT_SET || CMD == CMD_MARGIN_HI || CMD == CMD_MARGIN_LO) begin
         wr_ok = WDATA >= VOUT_MIN && WDATA <= VOUT_MAX;
      end else begin
         known = 1'b0;
      end
      wr_bad = WR_STB && known && !wr_ok;
   end

   // settings update only on accepted writes; nothing persists here
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         op_q <= OP_RST;
         cfg_cmd_q <= CFG_RST[CFG_CMD_BIT];
         vin_on_q <= VIN_ON_RST;
         vin_off_q <= VIN_OFF_RST;
         dly_q <= TON_DLY_RST;
         rise_q <= SOFT_START_RISE_TIME_RST;
         vout_q <= VOUT_RST;
         mhi_q <= MHI_RST;
         mlo_q <= MLO_RST;
      end else if (CE && WR_STB && wr_ok) begin
         if (CMD == CMD_OPERATION) op_q <= WDATA[7:0];
         if (CMD == CMD_ONOFF_CFG) cfg_cmd_q <= WDATA[CFG_CMD_BIT];
         if (CMD == CMD_VIN_ON) vin_on_q <= w_mant;
         if (CMD == CMD_VIN_OFF) vin_off_q <= w_mant;
         if (CMD == CMD_TURN_ON_DELAY_TIME) dly_q <= w_mant;
         if (CMD == CMD_SOFT_START_RISE_TIME) rise_q <= w_mant;
         if (CMD == CMD_VOUT_SET) vout_q <= WDATA;
         if (CMD == CMD_MARGIN_HI) mhi_q <= WDATA;
         if (CMD == CMD_MARGIN_LO) mlo_q <= WDATA;
      end
   end

   // error pulses and store request
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         CMD_ERR <= 1'b0;
         DATA_ERR <= 1'b0;
         NV_STORE <= 1'b0;
      end else if (CE) begin
         CMD_ERR <= (WR_STB || RD_STB) && !known && !(RD_STB && CMD == CMD_VOUT_MODE)
            && !(RD_STB && (CMD == CMD_VIN_READ || CMD == CMD_VOUT_READ || CMD == CMD_VIN_OFS
            || CMD == CMD_VIN_GAIN || CMD == CMD_VOUT_OFS));
         DATA_ERR <= wr_bad;
         NV_STORE <= WR_STB && CMD == CMD_STORE_ALL;
      end
   end

   // readback multiplexer
   // unknown read codes return zero with RVALID still pulsed, so the host never waits
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         RDATA <= 16'h0000;
         RVALID <= 1'b0;
      end else if (CE) begin
         RVALID <= RD_STB;
         if (RD_STB) begin
            if (CMD == CMD_OPERATION) RDATA <= {8'h00, op_q};
            else if (CMD == CMD_ONOFF_CFG) RDATA <= {11'h000, CFG_RST[4], cfg_cmd_q, CFG_RST[2:0]};
            else if (CMD == CMD_VOUT_MODE) RDATA <= {8'h00, VOUT_MODE_VAL};
            else if (CMD == CMD_VIN_ON) RDATA <= {EXP_M3, vin_on_q};
            else if (CMD == CMD_VIN_OFF) RDATA <= {EXP_M3, vin_off_q};
            else if (CMD == CMD_TURN_ON_DELAY_TIME) RDATA <= {EXP_M1, dly_q};
            else if (CMD == CMD_SOFT_START_RISE_TIME) RDATA <= {EXP_M1, rise_q};
            else if (CMD == CMD_VOUT_SET) RDATA <= vout_q;
            else if (CMD == CMD_MARGIN_HI) RDATA <= mhi_q;
            else if (CMD == CMD_MARGIN_LO) RDATA <= mlo_q;
            else if (CMD == CMD_VOUT_READ) RDATA <= rb_vout;
            else if (CMD == CMD_VOUT_OFS) RDATA <= NV_VOUT_OFS;
            else if (CMD == CMD_VIN_READ) RDATA <= {EXP_M3, rb_vin};
            else if (CMD == CMD_VIN_OFS) RDATA <= {EXP_M3, NV_VIN_OFS};
            else if (CMD == CMD_VIN_GAIN) RDATA <= NV_VIN_GAIN;
            else RDATA <= 16'h0000;
         end
      end
   end

   // corrected readings
   // the corrector sees the factory words live, so a reading follows them one edge later
   pmcc_cal u_cal (
      .CLOCK(CLOCK),
      .RST(RST),
      .CE(CE),
      .vout_raw(VOUT_ADC),
      .vout_ofs(NV_VOUT_OFS),
      .vin_raw(VIN_ADC),
      .vin_ofs(NV_VIN_OFS),
      .vin_gain(NV_VIN_GAIN),
      .vout_q(rb_vout),
      .vin_q(rb_vin)
   );

   // start request: pin always required, command bit honoured when enabled
   assign run_req = EN_PIN && (!cfg_cmd_q || op_q[OP_ON_BIT]);

   // margin selection from operation bits 5:2
   // codes outside the two margin codes fall back to the nominal set point
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         VOUT_TARGET <= VOUT_RST;
      end else if (CE) begin
         if (op_q[5:2] == 4'b0110) VOUT_TARGET <= mlo_q;
         else if (op_q[5:2] == 4'b1010) VOUT_TARGET <= mhi_q;
         else VOUT_TARGET <= vout_q;
      end
   end

   // half-millisecond tick, restarted on each phase change
   // the tick rests at zero outside timed phases so each phase starts on a whole step
   assign step = (tick_q == 32'(STEP_CYCLES - 1));
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         tick_q <= 32'h0000_0000;
      end else if (CE) begin
         if (st_q == PMCC_OFF || st_q == PMCC_ON || step) tick_q <= 32'h0000_0000;
         else tick_q <= tick_q + 32'h0000_0001;
      end
   end

   // start sequencer: off, delay, rise, on
   // losing the pin or the command drops straight back to off from any state
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         st_q <= PMCC_OFF;
         RAMP_CNT <= 16'h0000;
      end else if (CE) begin
         if (!run_req) begin
            st_q <= PMCC_OFF;
            RAMP_CNT <= 16'h0000;
         end else begin
            case (st_q)
               PMCC_OFF: begin
                  st_q <= PMCC_DELAY;
                  RAMP_CNT <= 16'h0000;
               end
               PMCC_DELAY: begin
                  if (step && RAMP_CNT == 16'(dly_q) - 16'h0001) begin
                     st_q <= PMCC_RISE;
                     RAMP_CNT <= 16'h0000;
                  end else if (step) RAMP_CNT <= RAMP_CNT + 16'h0001;
               end
               PMCC_RISE: begin
                  if (step && RAMP_CNT == 16'(rise_q) - 16'h0001) begin
                     st_q <= PMCC_ON;
                     RAMP_CNT <= 16'h0000;
                  end else if (step) RAMP_CNT <= RAMP_CNT + 16'h0001;
               end
               default: RAMP_CNT <= 16'h0000;
            endcase
         end
      end
   end

   assign OUT_EN = (st_q == PMCC_RISE) || (st_q == PMCC_ON);
   assign RAMPING = (st_q == PMCC_RISE);

   // assertions: start control
   a_pin_gates_out: assert property (@(posedge CLOCK) disable iff (RST)
      CE && !EN_PIN |=> !OUT_EN)
      else $error("output on without pin");
   a_cmd_ignored: assert property (@(posedge CLOCK) disable iff (RST)
      CE && !cfg_cmd_q && EN_PIN && st_q == PMCC_OFF |=> st_q == PMCC_DELAY)
      else $error("start not taken with command ignored");
   a_op_off: assert property (@(posedge CLOCK) disable iff (RST)
      CE && cfg_cmd_q && !op_q[OP_ON_BIT] |=> st_q == PMCC_OFF)
      else $error("on with enable bit clear");
   a_delay_before_rise: assert property (@(posedge CLOCK) disable iff (RST)
      st_q == PMCC_OFF ##1 st_q == PMCC_DELAY |=> !OUT_EN)
      else $error("ramp without delay");

   // assertions: command decode and storage
   a_op_write: assert property (@(posedge CLOCK) disable iff (RST)
      CE && WR_STB && CMD == CMD_OPERATION |=> op_q == $past(WDATA[7:0]))
      else $error("operation byte not taken");
   a_cfg_writable: assert property (@(posedge CLOCK) disable iff (RST)
      CE && WR_STB && CMD == CMD_ONOFF_CFG |=> cfg_cmd_q == $past(WDATA[CFG_CMD_BIT]))
      else $error("command bit not written");
   a_cfg_read: assert property (@(posedge CLOCK) disable iff (RST)
      CE && RD_STB && CMD == CMD_ONOFF_CFG |=> RVALID && RDATA[15:4] == 12'h001 && RDATA[2:0] == 3'h7)
      else $error("config fixed bits wrong");
   a_bad_flagged: assert property (@(posedge CLOCK) disable iff (RST)
      CE && WR_STB && CMD == CMD_VOUT_SET && WDATA > VOUT_MAX |=> DATA_ERR && $stable(vout_q))
      else $error("bad set point not refused");
   a_thr_exp: assert property (@(posedge CLOCK) disable iff (RST)
      CE && WR_STB && CMD == CMD_VIN_OFF && !lin_ok_m3 |=> DATA_ERR && $stable(vin_off_q))
      else $error("threshold with wrong format taken");
   a_store_pulse: assert property (@(posedge CLOCK) disable iff (RST)
      CE && WR_STB && CMD == CMD_STORE_ALL |=> NV_STORE
      ##1 (!NV_STORE || !$past(CE) || $past(WR_STB && CMD == CMD_STORE_ALL)))
      else $error("store pulse missing");
   a_store_only: assert property (@(posedge CLOCK) disable iff (RST)
      CE && !(WR_STB && CMD == CMD_STORE_ALL) |=> !NV_STORE)
      else $error("store pulse without command");
   a_ro_write: assert property (@(posedge CLOCK) disable iff (RST)
      CE && WR_STB && CMD == CMD_VOUT_READ |=> CMD_ERR && !DATA_ERR)
      else $error("write to reading not refused");

   // assertions: held settings stay in range
   a_vin_range: assert property (@(posedge CLOCK) disable iff (RST)
      vin_on_q >= VIN_MIN && vin_on_q <= VIN_MAX && vin_off_q >= VIN_MIN && vin_off_q <= VIN_MAX)
      else $error("threshold out of range");
   a_time_range: assert property (@(posedge CLOCK) disable iff (RST)
      dly_q >= DLY_MIN && dly_q <= TIME_MAX && rise_q >= RISE_MIN && rise_q <= TIME_MAX)
      else $error("timing setting out of range");
   a_vout_range: assert property (@(posedge CLOCK) disable iff (RST)
      vout_q >= VOUT_MIN && vout_q <= VOUT_MAX && mhi_q >= VOUT_MIN && mhi_q <= VOUT_MAX
      && mlo_q >= VOUT_MIN && mlo_q <= VOUT_MAX)
      else $error("set point out of range");

   // assertions: margin selection
   a_margin_hi: assert property (@(posedge CLOCK) disable iff (RST)
      CE && op_q[5:2] == 4'b1010 |=> VOUT_TARGET == $past(mhi_q))
      else $error("margin high not used");
   a_margin_lo: assert property (@(posedge CLOCK) disable iff (RST)
      CE && op_q[5:2] == 4'b0110 |=> VOUT_TARGET == $past(mlo_q))
      else $error("margin low not used");
   a_margin_off: assert property (@(posedge CLOCK) disable iff (RST)
      CE && op_q[5:4] == 2'b00 |=> VOUT_TARGET == $past(vout_q))
      else $error("nominal set point not used");

   // assertions: readback formats
   a_mode_read: assert property (@(posedge CLOCK) disable iff (RST)
      CE && RD_STB && CMD == CMD_VOUT_MODE |=> RDATA == 16'h0014)
      else $error("mode byte wrong");
   a_thr_read: assert property (@(posedge CLOCK) disable iff (RST)
      CE && RD_STB && CMD == CMD_VIN_OFF |=> RDATA[15:11] == EXP_M3 && !RDATA[10])
      else $error("threshold read format wrong");
   a_dly_read: assert property (@(posedge CLOCK) disable iff (RST)
      CE && RD_STB && CMD == CMD_TURN_ON_DELAY_TIME |=> RDATA[15:11] == EXP_M1 && !RDATA[10])
      else $error("delay read format wrong");
   a_vin_read_exp: assert property (@(posedge CLOCK) disable iff (RST)
      CE && RD_STB && CMD == CMD_VIN_READ |=> RDATA[15:11] == EXP_M3 && !RDATA[10])
      else $error("input reading format wrong");
   a_vout_ofs_read: assert property (@(posedge CLOCK) disable iff (RST)
      CE && RD_STB && CMD == CMD_VOUT_OFS |=> RDATA == $past(NV_VOUT_OFS))
      else $error("output offset read wrong");
   a_vin_ofs_read: assert property (@(posedge CLOCK) disable iff (RST)
      CE && RD_STB && CMD == CMD_VIN_OFS |=> RDATA == {EXP_M3, $past(NV_VIN_OFS)})
      else $error("input offset read wrong");
   a_gain_read: assert property (@(posedge CLOCK) disable iff (RST)
      CE && RD_STB && CMD == CMD_VIN_GAIN |=> RDATA == $past(NV_VIN_GAIN))
      else $error("input gain read wrong");
endmodule
`default_nettype wire

// *** dv/pmcc_host.sv ***
`timescale 1ns/1ns
`default_nettype none
// host controller model: one command word per strobe, answer taken one edge later
module pmcc_host
   import pmcc_pkg::*;
(
   input wire logic CLOCK,
   input wire logic [15:0] RDATA,
   input wire logic RVALID,
   input wire logic CMD_ERR,
   input wire logic DATA_ERR,
   output logic WR_STB,
   output logic RD_STB,
   output logic [7:0] CMD,
   output logic [15:0] WDATA
);
   // idle bus at time zero
   initial begin
      WR_STB = 1'b0;
      RD_STB = 1'b0;
      CMD = 8'h00;
      WDATA = 16'h0000;
   end

   // one transfer: request held over one edge, answer sampled just after that same edge
   task automatic xfer(input logic rd, input logic [7:0] c, input logic [15:0] d,
                       output logic [15:0] q, output logic [2:0] fl);
      @(posedge CLOCK);
      WR_STB <= !rd;
      RD_STB <= rd;
      CMD <= c;
      WDATA <= d;
      @(posedge CLOCK);
      WR_STB <= 1'b0;
      RD_STB <= 1'b0;
      // released lines must not keep showing the last value
      CMD <= ~c;
      WDATA <= ~d;
      #1;
      q = RDATA;
      fl = {RVALID, CMD_ERR, DATA_ERR};
   endtask
endmodule
`default_nettype wire

// *** dv/test_power_module_pmbus_control_cmds.sv ***
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin \
   checked++; \
   if ((g) !== (e)) begin \
      failures++; \
      $display("CHECK FAILED at %0t: got %h expected %h", $time, (g), (e)); \
   end \
end
module test_power_module_pmbus_control_cmds
   import pmcc_pkg::*;
();
   localparam int SC = 2; // short half-millisecond step
   // range table: command, word, refused
   localparam logic [7:0] TC [18] = '{CMD_VIN_OFF, CMD_VIN_OFF, CMD_VIN_OFF, CMD_VIN_OFF, CMD_VIN_ON,
      CMD_VIN_ON, CMD_VIN_ON, CMD_TURN_ON_DELAY_TIME, CMD_TURN_ON_DELAY_TIME, CMD_TURN_ON_DELAY_TIME, CMD_SOFT_START_RISE_TIME, CMD_SOFT_START_RISE_TIME,
      CMD_SOFT_START_RISE_TIME, CMD_VOUT_SET, CMD_VOUT_SET, CMD_VOUT_SET, CMD_VOUT_SET, CMD_VOUT_SET};
   localparam logic [15:0] TD [18] = '{16'hE900, 16'hE8FF, 16'hE971, 16'hF100, 16'hE970, 16'hE910,
      16'hEC10, 16'hFBE8, 16'hFBE9, 16'hF813, 16'hF81E, 16'hF81D, 16'hFBE9, 16'h819A, 16'h8199,
      16'hD333, 16'hD334, 16'hC000};
   localparam logic TE [18] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1,
      1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
   // margin codes and the set point each selects
   localparam logic [3:0] MB [5] = '{4'h0, 4'h3, 4'h6, 4'hA, 4'h1};
   localparam logic [15:0] MT [5] = '{16'hC000, 16'hC000, 16'h9000, 16'hD000, 16'hC000};
   logic CLOCK = 1'b0, RST = 1'b1, CE = 1'b1, EN_PIN = 1'b0;
   logic WR_STB, RD_STB, RVALID, CMD_ERR, DATA_ERR, NV_STORE, OUT_EN, RAMPING;
   logic [7:0] CMD;
   logic [15:0] WDATA, RDATA, VOUT_TARGET, RAMP_CNT;
   logic [15:0] VOUT_ADC = 16'h1000, NV_VOUT_OFS = 16'hFFF0, NV_VIN_GAIN = 16'h3000;
   logic [10:0] VIN_ADC = 11'h180, NV_VIN_OFS = 11'h7F8;
   logic [15:0] q, acc;
   logic [2:0] fl;
   int checked = 0, failures = 0;

   pmcc_top #(.STEP_CYCLES(SC)) dut (.CLOCK(CLOCK), .RST(RST), .CE(CE), .WR_STB(WR_STB), .RD_STB(RD_STB),
      .CMD(CMD), .WDATA(WDATA), .RDATA(RDATA), .RVALID(RVALID), .CMD_ERR(CMD_ERR), .DATA_ERR(DATA_ERR),
      .EN_PIN(EN_PIN), .VOUT_ADC(VOUT_ADC), .VIN_ADC(VIN_ADC), .NV_VOUT_OFS(NV_VOUT_OFS),
      .NV_VIN_OFS(NV_VIN_OFS), .NV_VIN_GAIN(NV_VIN_GAIN), .NV_STORE(NV_STORE), .OUT_EN(OUT_EN),
      .RAMPING(RAMPING), .VOUT_TARGET(VOUT_TARGET), .RAMP_CNT(RAMP_CNT));
   pmcc_host host (.CLOCK(CLOCK), .RDATA(RDATA), .RVALID(RVALID), .CMD_ERR(CMD_ERR), .DATA_ERR(DATA_ERR),
      .WR_STB(WR_STB), .RD_STB(RD_STB), .CMD(CMD), .WDATA(WDATA));

   // free-running clock
   always #5 CLOCK = ~CLOCK;

   // prints counts and verdict, ends the run
   task automatic conclude;
      $display("checked %0d failures %0d", checked, failures);
      if (checked > 0 && failures == 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // write and compare the flags {valid, command error, data error}
   task automatic wrc(input logic [7:0] c, input logic [15:0] d, input logic [2:0] e);
      host.xfer(1'b0, c, d, q, fl);
      `CHK(fl, e)
      `CHK(NV_STORE, c == CMD_STORE_ALL)
   endtask

   // read and compare the masked word
   task automatic rdc(input logic [7:0] c, input logic [15:0] m, input logic [15:0] e);
      host.xfer(1'b1, c, 16'h0000, q, fl);
      `CHK(fl, 3'b100)
      `CHK(q & m, e)
   endtask

   // moves the enable pin at a rising edge
   task automatic pin(input logic v);
      @(posedge CLOCK);
      EN_PIN <= v;
   endtask

   // output must be off one edge later
   task automatic offnext;
      @(posedge CLOCK);
      #1;
      `CHK(OUT_EN, 1'b0)
   endtask

   // measures delay until enable, then ramp length, in cycles
   task automatic ramp(input int d, input int r);
      int n;
      n = 0;
      while (OUT_EN !== 1'b1 && n < 3000) begin
         @(posedge CLOCK);
         #1;
         n++;
      end
      `CHK(n >= d * SC && n <= d * SC + 2, 1'b1)
      n = 0;
      while (RAMPING === 1'b1 && n < 3000) begin
         @(posedge CLOCK);
         #1;
         n++;
         if (RAMPING === 1'b1) `CHK(RAMP_CNT, 16'(n / SC))
      end
      `CHK(n, r * SC)
      `CHK(OUT_EN, 1'b1)
   endtask

   // main sequence
   initial begin
      repeat (2) @(posedge CLOCK);
      RST <= 1'b0;
      rdc(CMD_ONOFF_CFG, 16'h001F, 16'h001F);
      rdc(CMD_VOUT_MODE, 16'h00FF, 16'h0014);
      rdc(CMD_VOUT_SET, 16'hFFFF, 16'hC000);
      wrc(CMD_ONOFF_CFG, 16'h0000, 3'b000);
      rdc(CMD_ONOFF_CFG, 16'h001F, 16'h0017);
      pin(1'b1);
      ramp(20, 30);
      pin(1'b0);
      offnext();
      wrc(CMD_ONOFF_CFG, 16'h0008, 3'b000);
      wrc(CMD_OPERATION, 16'h0080, 3'b000);
      repeat (60) @(posedge CLOCK);
      #1;
      `CHK(OUT_EN, 1'b0)
      wrc(CMD_TURN_ON_DELAY_TIME, 16'hF828, 3'b000);
      wrc(CMD_SOFT_START_RISE_TIME, 16'hF81F, 3'b000);
      pin(1'b1);
      ramp(40, 31);
      wrc(CMD_OPERATION, 16'h0000, 3'b000);
      offnext();
      wrc(CMD_OPERATION, 16'h0080, 3'b000);
      ramp(40, 31);
      wrc(CMD_ONOFF_CFG, 16'h0000, 3'b000);
      wrc(CMD_OPERATION, 16'h0000, 3'b000);
      repeat (5) @(posedge CLOCK);
      #1;
      `CHK(OUT_EN, 1'b1)
      pin(1'b0);
      offnext();
      wrc(CMD_ONOFF_CFG, 16'h0008, 3'b000);
      for (int i = 0; i < 18; i++) begin
         wrc(TC[i], TD[i], {2'b00, TE[i]});
         if (!TE[i]) begin
            acc = TD[i];
         end
         rdc(TC[i], 16'hFFFF, acc);
      end
      wrc(CMD_MARGIN_HI, 16'hD000, 3'b000);
      wrc(CMD_MARGIN_LO, 16'h9000, 3'b000);
      rdc(CMD_MARGIN_LO, 16'hFFFF, 16'h9000);
      for (int i = 0; i < 5; i++) begin
         wrc(CMD_OPERATION, {8'h00, 2'b10, MB[i], 2'b00}, 3'b000);
         @(posedge CLOCK);
         #1;
         `CHK(VOUT_TARGET, MT[i])
      end
      rdc(CMD_OPERATION, 16'hFFFF, 16'h0084);
      rdc(CMD_MARGIN_HI, 16'hFFFF, 16'hD000);
      // a write while the clock enable is low must leave the set point alone
      @(posedge CLOCK);
      CE <= 1'b0;
      wrc(CMD_VOUT_SET, 16'hC800, 3'b000);
      @(posedge CLOCK);
      CE <= 1'b1;
      rdc(CMD_VOUT_SET, 16'hFFFF, 16'hC000);
      rdc(CMD_VOUT_READ, 16'hFFFF, 16'h0FF0);
      rdc(CMD_VOUT_OFS, 16'hFFFF, 16'hFFF0);
      rdc(CMD_VIN_READ, 16'hFFFF, 16'hEA38);
      rdc(CMD_VIN_OFS, 16'hFFFF, 16'hEFF8);
      rdc(CMD_VIN_GAIN, 16'hFFFF, 16'h3000);
      wrc(CMD_VOUT_READ, 16'h0000, 3'b010);
      wrc(8'h77, 16'h0000, 3'b010);
      wrc(CMD_STORE_ALL, 16'h0000, 3'b000);
      conclude();
   end

   // watchdog: the sequence needs about 600 cycles, allow far more
   initial begin
      #200000;
      failures++;
      conclude();
   end
endmodule
`default_nettype wire
